// *** common/qfr_defines.svh ***
// constants for the quad flash read and program sequencer
`ifndef QFR_DEFINES_SVH
`define QFR_DEFINES_SVH
`define QFR_OP_QREAD 8'hEB
`define QFR_OP_QREAD_WIDE 8'hEC
`define QFR_OP_PAGE 8'h02
`define QFR_OP_PAGE_WIDE 8'h12
`define QFR_OP_QPAGE_A 8'h32
`define QFR_OP_QPAGE_B 8'h38
`define QFR_OP_QPAGE_WIDE_A 8'h34
`define QFR_OP_QPAGE_WIDE_B 8'h3E
`define QFR_OP_PERMIT 8'h06
`define QFR_MODE_SKIP_NIB 4'hA
`define QFR_OPCODE_BITS 6'h08
`define QFR_ADDR_BITS_NARROW 6'h18
`define QFR_ADDR_BITS_WIDE 6'h20
`define QFR_MODE_BITS 6'h08
`define QFR_MODE_CYCLES 4'h2
`define QFR_PAGE_BYTES 9'h100
`define QFR_SECTOR_LOG2 6'h0C
`define QFR_BLOCK32_LOG2 6'h0F
`define QFR_BLOCK64_LOG2 6'h10
`define QFR_WIPE_SECTOR 2'h0
`define QFR_WIPE_BLOCK32 2'h1
`define QFR_WIPE_BLOCK64 2'h2
`endif

// *** common/qfr_pkg.sv ***
// types shared by the quad flash read and program sequencer
package qfr_pkg;
    typedef struct packed {
        logic four_wire_command_mode;
        logic quad_lines_enable;
        logic wide_address_select;
        logic [3:0] dummy_cycles;
    } qfr_cfg_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
    } qfr_prog_word_type;

    typedef struct packed {
        logic valid;
        logic [31:0] base;
        logic [5:0] size_log2;
    } qfr_wipe_type;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_RDATA, ST_PCHK, ST_PDATA, ST_IGNORE
    } qfr_frame_type;

    typedef enum logic [1:0] {CM_IDLE, CM_SCAN, CM_WAIT, CM_PUSH} qfr_commit_type;
endpackage

// *** core/qfr_ctl.sv ***
// serial flash command sequencer: quad read, page program, wipe regions
// Behaviour
// RL1: mode nibble A keeps next read opcode-less
// RL2: four-wire mode quad read ignores quad enable
// RL3: four-wire opcode arrives as two nibbles
// RL4: host sends mode byte after address
// RL5: only mode bits 7..4 equal 1010 skip
// RL6: after read, ready for opcode, mode kept
// RL7: dummy count includes the two mode cycles
// RL8: quad read ignored while operation in progress
// RL9: host floats low mode nibble when needed
// RL10: EBh selectable address width, ECh four bytes
// RL11: read phases identical in both command modes
// RL12: 02h selectable width, 12h four bytes, data
// RL13: program into protected page is ignored
// RL14: host sets write permit before program
// RL15: program starts only on chip-select release
// RL16: progress flag high until program finishes
// RL17: data wraps in page, last 256 kept
// RL18: programming only clears bits
// RL19: host enables quad lines before quad program
// RL20: 32h/38h selectable width, 34h/3Eh four bytes
// RL21: 4K sectors, 32K and 64K blocks
// RL22: wipe sets region to ones, others untouched
// RL23: write permit cleared when operation completes
// RL24: in-page byte address advances modulo page
`include "qfr_defines.svh"
module qfr_ctl (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe,
    input wire qfr_pkg::qfr_cfg_type i_cfg,
    input wire logic i_ext_busy,
    output logic [31:0] o_check_addr,
    input wire logic i_addr_protected,
    output logic [31:0] o_mem_addr,
    input wire logic [7:0] i_mem_rdata,
    output logic o_prog_valid,
    input wire logic i_prog_ready,
    output qfr_pkg::qfr_prog_word_type o_prog_word,
    input wire logic i_wipe_req,
    input wire logic [1:0] i_wipe_kind,
    input wire logic [31:0] i_wipe_addr,
    input wire logic i_wipe_done,
    output qfr_pkg::qfr_wipe_type o_wipe,
    output logic o_op_in_progress_flag,
    output logic o_write_permit_latch
);
    import qfr_pkg::*;

    logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3;
    logic [3:0] io_s1, io_s2;
    logic rise, fall, desel, busy, quad_now, byte_wr, commit_go, commit_done, fifo_push;
    logic [5:0] lw, ncnt, alen;
    logic [31:0] sh_q, nxt_sh, addr_q;
    logic [5:0] cnt_q;
    logic [3:0] dcnt_q, io_q;
    logic [7:0] pidx_q;
    logic rd_q, wide_q, aquad_q, dquad_q, skip_q, any_q, nib_q, oe_q, permit_set_q;
    logic permit_q, cbusy_q;
    qfr_frame_type state_q;
    qfr_commit_type cm_q;
    logic [8:0] idx_q;
    logic [23:0] cpage_q;
    logic [7:0] page_mem [0:255];
    logic [255:0] mask_q;
    qfr_prog_word_type fifo_mem [0:1];
    qfr_prog_word_type push_word;
    logic [1:0] fcnt_q;
    logic fwp_q, frp_q;
    logic [31:0] mem_addr_q;
    qfr_wipe_type wipe_q;

    // pin synchronisers and link clock edge finding
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end else if (i_ce) begin
            sck_s1 <= i_sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            io_s1 <= i_io;
            io_s2 <= io_s1;
        end
    end

    assign rise = i_ce & sck_s2 & ~sck_s3 & ~cs_s2;
    assign fall = i_ce & ~sck_s2 & sck_s3 & ~cs_s2;
    assign desel = i_ce & cs_s2 & ~cs_s3;
    assign busy = cbusy_q | i_ext_busy;

    // lines used by the current phase and next shift value
    always_comb begin
        unique case (state_q)
            ST_CMD: quad_now = i_cfg.four_wire_command_mode;
            ST_ADDR: quad_now = aquad_q;
            ST_MODE: quad_now = 1'b1;
            ST_PDATA: quad_now = dquad_q;
            default: quad_now = 1'b0;
        endcase
        lw = quad_now ? 6'h04 : 6'h01;
        ncnt = cnt_q + lw;
        nxt_sh = quad_now ? {sh_q[27:0], io_s2} : {sh_q[30:0], io_s2[0]};
        alen = wide_q ? `QFR_ADDR_BITS_WIDE : `QFR_ADDR_BITS_NARROW;
    end

    assign byte_wr = rise && state_q == ST_PDATA && ncnt == 6'h08;

    // frame sequencer: opcode, address, mode, dummy, data
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_CMD;
            cnt_q <= 6'h00;
            sh_q <= 32'h0000_0000;
            addr_q <= 32'h0000_0000;
            {rd_q, wide_q, aquad_q, dquad_q, skip_q, any_q, nib_q} <= 7'h00;
            dcnt_q <= 4'h0;
            pidx_q <= 8'h00;
            permit_set_q <= 1'b0;
        end else if (i_ce) begin
            permit_set_q <= 1'b0;
            if (cs_s2) begin
                // RL1: skip read starts straight at the address
                // RL6: idle frame waits for a new opcode
                state_q <= skip_q ? ST_ADDR : ST_CMD;
                cnt_q <= 6'h00;
                nib_q <= 1'b0;
            end else if (state_q == ST_PCHK) begin
                // RL13: protected page drops the whole program
                state_q <= i_addr_protected ? ST_IGNORE : ST_PDATA;
                pidx_q <= addr_q[7:0];
            end else if (fall && state_q == ST_RDATA) begin
                nib_q <= ~nib_q;
                if (nib_q) begin
                    addr_q <= addr_q + 32'h0000_0001;
                end
            end else if (rise) begin
                sh_q <= nxt_sh;
                cnt_q <= ncnt;
                unique case (state_q)
                    ST_CMD: begin
                        // RL3: four-wire opcode completes in two clocks
                        if (ncnt == `QFR_OPCODE_BITS) begin
                            cnt_q <= 6'h00;
                            state_q <= ST_IGNORE;
                            aquad_q <= i_cfg.four_wire_command_mode;
                            dquad_q <= i_cfg.four_wire_command_mode;
                            any_q <= 1'b0;
                            unique case (nxt_sh[7:0])
                                `QFR_OP_QREAD, `QFR_OP_QREAD_WIDE: begin
                                    // RL2: four-wire mode skips the quad enable check
                                    // RL8: reads during an operation are ignored
                                    // RL10: ECh forces four address bytes
                                    // RL11: address, mode, dummy and data on four lines
                                    if (!busy && (i_cfg.four_wire_command_mode
                                            || i_cfg.quad_lines_enable)) begin
                                        state_q <= ST_ADDR;
                                        rd_q <= 1'b1;
                                        aquad_q <= 1'b1;
                                        wide_q <= nxt_sh[7:0] == `QFR_OP_QREAD_WIDE
                                            || i_cfg.wide_address_select;
                                    end
                                end
                                `QFR_OP_PAGE, `QFR_OP_PAGE_WIDE: begin
                                    // RL12: 12h forces four address bytes
                                    if (!busy && permit_q) begin
                                        state_q <= ST_ADDR;
                                        rd_q <= 1'b0;
                                        wide_q <= nxt_sh[7:0] == `QFR_OP_PAGE_WIDE
                                            || i_cfg.wide_address_select;
                                    end
                                end
                                `QFR_OP_QPAGE_A, `QFR_OP_QPAGE_B,
                                `QFR_OP_QPAGE_WIDE_A, `QFR_OP_QPAGE_WIDE_B: begin
                                    // RL20: 34h and 3Eh force four address bytes
                                    if (!busy && permit_q && (i_cfg.quad_lines_enable
                                            || i_cfg.four_wire_command_mode)) begin
                                        state_q <= ST_ADDR;
                                        rd_q <= 1'b0;
                                        dquad_q <= 1'b1;
                                        wide_q <= nxt_sh[7:0] == `QFR_OP_QPAGE_WIDE_A
                                            || nxt_sh[7:0] == `QFR_OP_QPAGE_WIDE_B
                                            || i_cfg.wide_address_select;
                                    end
                                end
                                `QFR_OP_PERMIT: permit_set_q <= !busy;
                                default: state_q <= ST_IGNORE;
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        if (ncnt == alen) begin
                            cnt_q <= 6'h00;
                            addr_q <= wide_q ? nxt_sh : {8'h00, nxt_sh[23:0]};
                            if (rd_q && busy) begin
                                state_q <= ST_IGNORE;
                            end else begin
                                state_q <= rd_q ? ST_MODE : ST_PCHK;
                            end
                        end
                    end
                    ST_MODE: begin
                        if (ncnt == `QFR_MODE_BITS) begin
                            // RL5: only the upper mode nibble decides
                            skip_q <= nxt_sh[7:4] == `QFR_MODE_SKIP_NIB;
                            // RL7: mode cycles count toward the dummy total
                            dcnt_q <= i_cfg.dummy_cycles - `QFR_MODE_CYCLES;
                            state_q <= (i_cfg.dummy_cycles <= `QFR_MODE_CYCLES)
                                ? ST_RDATA : ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        dcnt_q <= dcnt_q - 4'h1;
                        if (dcnt_q <= 4'h1) begin
                            state_q <= ST_RDATA;
                        end
                    end
                    ST_PDATA: begin
                        if (byte_wr) begin
                            // RL24: byte pointer wraps inside the page
                            cnt_q <= 6'h00;
                            pidx_q <= pidx_q + 8'h01;
                            any_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    assign o_check_addr = addr_q;

    // page buffer; later bytes overwrite earlier ones at the same offset
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && byte_wr) begin
            // RL17: only the last 256 bytes survive
            page_mem[pidx_q] <= nxt_sh[7:0];
        end
    end

    // written-byte mask so untouched bytes stay unchanged
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_q <= '0;
        end else if (i_ce) begin
            if (state_q == ST_PCHK) begin
                mask_q <= '0;
            end else if (byte_wr) begin
                mask_q[pidx_q] <= 1'b1;
            end
        end
    end

    // RL15: only a clean release after whole bytes starts programming
    assign commit_go = desel && state_q == ST_PDATA && any_q && cnt_q == 6'h00;
    assign commit_done = i_ce && cm_q == CM_SCAN && idx_q[8] && fcnt_q == 2'h0;
    // RL18: old data masked so bits can only fall to zero
    assign push_word = '{addr: {cpage_q, idx_q[7:0]}, data: i_mem_rdata & page_mem[idx_q[7:0]]};
    assign fifo_push = i_ce && cm_q == CM_PUSH && fcnt_q != 2'h2;

    // commit engine walks the page and queues the written bytes
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cm_q <= CM_IDLE;
            idx_q <= 9'h000;
            cpage_q <= 24'h00_0000;
            cbusy_q <= 1'b0;
        end else if (i_ce) begin
            unique case (cm_q)
                CM_IDLE: begin
                    if (commit_go) begin
                        // RL16: progress flag rises with the commit
                        cm_q <= CM_SCAN;
                        cbusy_q <= 1'b1;
                        idx_q <= 9'h000;
                        cpage_q <= addr_q[31:8];
                    end
                end
                CM_SCAN: begin
                    if (idx_q[8]) begin
                        // RL16: flag falls once the page is scanned and the buffer drained
                        if (fcnt_q == 2'h0) begin
                            cm_q <= CM_IDLE;
                            cbusy_q <= 1'b0;
                        end
                    end else if (mask_q[idx_q[7:0]]) begin
                        cm_q <= CM_WAIT;
                    end else begin
                        idx_q <= idx_q + 9'h001;
                    end
                end
                CM_WAIT: cm_q <= CM_PUSH;
                CM_PUSH: begin
                    if (fifo_push) begin
                        idx_q <= idx_q + 9'h001;
                        cm_q <= CM_SCAN;
                    end
                end
            endcase
        end
    end

    // two-entry program word buffer toward the array writer
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fcnt_q <= 2'h0;
            fwp_q <= 1'b0;
            frp_q <= 1'b0;
        end else if (i_ce) begin
            if (fifo_push) begin
                fifo_mem[fwp_q] <= push_word;
                fwp_q <= ~fwp_q;
            end
            if (o_prog_valid && i_prog_ready) begin
                frp_q <= ~frp_q;
            end
            fcnt_q <= fcnt_q + {1'b0, fifo_push} - {1'b0, o_prog_valid && i_prog_ready};
        end
    end

    assign o_prog_valid = fcnt_q != 2'h0;
    assign o_prog_word = fifo_mem[frp_q];

    // array address for read data and for old-data fetch
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_addr_q <= 32'h0000_0000;
        end else if (i_ce) begin
            mem_addr_q <= (cm_q != CM_IDLE) ? {cpage_q, idx_q[7:0]} : addr_q;
        end
    end

    assign o_mem_addr = mem_addr_q;

    // read data driven on falling link edges, high nibble first
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (i_ce) begin
            if (cs_s2 || state_q != ST_RDATA) begin
                oe_q <= 1'b0;
            end else if (fall) begin
                io_q <= nib_q ? i_mem_rdata[3:0] : i_mem_rdata[7:4];
                oe_q <= 1'b1;
            end
        end
    end

    assign o_io = io_q;
    assign o_io_oe = {4{oe_q}};

    // write permit latch; a new permit wins over a completion
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            permit_q <= 1'b0;
        end else if (i_ce) begin
            if (permit_set_q) begin
                permit_q <= 1'b1;
            end else if (commit_done || i_wipe_done) begin
                // RL23: completion clears the permit
                permit_q <= 1'b0;
            end
        end
    end

    assign o_write_permit_latch = permit_q;
    assign o_op_in_progress_flag = busy;

    // wipe region: aligned 4K sector or 32K/64K block
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wipe_q <= '0;
        end else if (i_ce) begin
            wipe_q.valid <= i_wipe_req;
            if (i_wipe_req) begin
                // RL21: region sizes of sector and blocks
                // RL22: base aligned so neighbours stay untouched
                unique case (i_wipe_kind)
                    `QFR_WIPE_SECTOR: wipe_q.size_log2 <= `QFR_SECTOR_LOG2;
                    `QFR_WIPE_BLOCK32: wipe_q.size_log2 <= `QFR_BLOCK32_LOG2;
                    default: wipe_q.size_log2 <= `QFR_BLOCK64_LOG2;
                endcase
                unique case (i_wipe_kind)
                    `QFR_WIPE_SECTOR: wipe_q.base <= {i_wipe_addr[31:12], 12'h000};
                    `QFR_WIPE_BLOCK32: wipe_q.base <= {i_wipe_addr[31:15], 15'h0000};
                    default: wipe_q.base <= {i_wipe_addr[31:16], 16'h0000};
                endcase
            end
        end
    end

    assign o_wipe = wipe_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_mode_end;
        rise && state_q == ST_MODE && ncnt == `QFR_MODE_BITS;
    endsequence

    a_skip_mode_set: assert property (s_mode_end |=> skip_q == ($past(nxt_sh[7:4]) == 4'b1010))
        else $error("skip mode not from mode nibble"); // RL5
    a_dummy_minimal: assert property (s_mode_end ##0 (i_cfg.dummy_cycles == 4'h2)
        |=> state_q == ST_RDATA) else $error("data late with two dummy cycles"); // RL7
    a_read_busy_drop: assert property (rise && state_q == ST_CMD && ncnt == 6'h08
        && nxt_sh[7:0] == 8'hEB && busy |=> state_q == ST_IGNORE)
        else $error("read accepted while busy"); // RL8
    a_qpi_cmd_two: assert property (rise && state_q == ST_CMD && i_cfg.four_wire_command_mode
        && cnt_q == 6'h04 |=> cnt_q == 6'h00) else $error("opcode not done in two clocks"); // RL3
    a_protect_drop: assert property (!cs_s2 && state_q == ST_PCHK && i_addr_protected
        |=> state_q == ST_IGNORE) else $error("protected page not ignored"); // RL13
    a_commit_on_cs: assert property ($rose(cbusy_q) |-> $past(desel))
        else $error("program began without release"); // RL15
    a_done_clears: assert property (commit_done && !permit_set_q
        |=> !cbusy_q && !permit_q) else $error("completion left flags set"); // RL23
    a_page_wrap: assert property (byte_wr && pidx_q == 8'hFF |=> pidx_q == 8'h00)
        else $error("byte pointer left the page"); // RL24
    a_prog_in_page: assert property (o_prog_valid && cm_q != CM_IDLE
        |-> o_prog_word.addr[31:8] == cpage_q) else $error("program word off page"); // RL17
    a_oe_read_only: assert property (oe_q |-> state_q == ST_RDATA || cs_s2)
        else $error("pins driven outside read data"); // RL6
endmodule

// *** verif/qfr_store_model.sv ***
// storage side model: array with read latency, stalling writer, protection map
module qfr_store_model (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [31:0] i_mem_addr,
    output logic [7:0] o_mem_rdata,
    input wire logic [31:0] i_check_addr,
    output logic o_addr_protected,
    input wire logic i_prog_valid,
    output logic o_prog_ready,
    input wire qfr_pkg::qfr_prog_word_type i_prog_word
);
    timeunit 1ns;
    timeprecision 100ps;
    import qfr_pkg::*;
    logic [7:0] mem_q [0:4095];
    logic [4:0] tick_q;
    // array starts with a per-address pattern the bench also knows
    initial begin
        for (int i = 0; i < 4096; i++) mem_q[i] = 8'(i) ^ 8'h5A;
    end
    // data one cycle after the address; pages 0xF00 to 0xFFF are protected
    always @(posedge i_sys_clk) o_mem_rdata <= mem_q[i_mem_addr[11:0]];
    assign o_addr_protected = (i_check_addr[11:8] == 4'hF);
    // writer stalls 16 of every 32 cycles so the buffer fills
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) tick_q <= 5'h00;
        else tick_q <= tick_q + 5'h01;
    end
    assign o_prog_ready = !tick_q[4];
    // words come pre-merged and are stored as is
    always @(posedge i_sys_clk) begin
        if (i_prog_valid && o_prog_ready) mem_q[i_prog_word.addr[11:0]] <= i_prog_word.data;
    end
endmodule

// *** verif/qfr_ctl_bench.sv ***
// bench for the flash sequencer: link host tasks, storage model, checks
module qfr_ctl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import qfr_pkg::*;
    logic clk, rstn, sck, cs_n, busy, wreq, wdone, prot, pvalid, pready, flag, permit, ce;
    logic [3:0] io, o_io, o_oe, rd;
    logic [1:0] wkind;
    logic [31:0] waddr, chk_a, mem_a;
    logic [7:0] mem_d;
    logic [7:0] shadow [0:4095];
    qfr_cfg_type cfg;
    qfr_prog_word_type pword;
    qfr_wipe_type wipe;
    int fails = 0;
    int samples_checked = 0;
    qfr_ctl dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_sck(sck), .i_cs_n(cs_n),
        .i_io(io), .o_io(o_io), .o_io_oe(o_oe), .i_cfg(cfg), .i_ext_busy(busy),
        .o_check_addr(chk_a), .i_addr_protected(prot), .o_mem_addr(mem_a),
        .i_mem_rdata(mem_d), .o_prog_valid(pvalid), .i_prog_ready(pready),
        .o_prog_word(pword), .i_wipe_req(wreq), .i_wipe_kind(wkind), .i_wipe_addr(waddr),
        .i_wipe_done(wdone), .o_wipe(wipe), .o_op_in_progress_flag(flag),
        .o_write_permit_latch(permit));
    qfr_store_model store_u (.i_sys_clk(clk), .i_rstn(rstn), .i_mem_addr(mem_a),
        .o_mem_rdata(mem_d), .i_check_addr(chk_a), .o_addr_protected(prot),
        .i_prog_valid(pvalid), .o_prog_ready(pready), .i_prog_word(pword));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one link clock: data set with the fall, read back late in the high phase
    task automatic sclk(input logic [3:0] v);
        io <= v;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        rd = o_io;
        sck <= 1'b0;
    endtask
    // one byte, msb first, as two nibbles or on io0
    task automatic sb(input logic [7:0] b, input bit q);
        if (q) begin
            sclk(b[7:4]);
            sclk(b[3:0]);
        end else begin
            for (int i = 7; i >= 0; i--) sclk({3'h7, b[i]});
        end
    endtask
    task automatic fr_on;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // release: lines float back to their pull-up level
    task automatic fr_off;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        io <= 4'hF;
        repeat (8) @(posedge clk);
    endtask
    // quad read of two bytes; opcode 0 means the opcode is skipped
    task automatic qread(input logic [7:0] op, input logic [31:0] a, input logic [7:0] m,
        input bit ign);
        logic [7:0] e;
        fr_on;
        if (op != 8'h00) sb(op, cfg.four_wire_command_mode);
        if (op == 8'hEC) sb(a[31:24], 1'b1);
        sb(a[23:16], 1'b1);
        sb(a[15:8], 1'b1);
        sb(a[7:0], 1'b1);
        sb(m, 1'b1);
        repeat (cfg.dummy_cycles - 2) sclk(4'hF);
        for (int k = 0; k < 4; k++) begin
            sclk(4'hF);
            e = shadow[a[11:0] + 12'(k / 2)];
            chk(o_oe, ign ? 4'h0 : 4'hF);
            if (!ign) chk(rd, k[0] ? e[3:0] : e[7:4]);
        end
        fr_off;
        chk(o_oe, 4'h0);
    endtask
    task automatic permit_frame;
        fr_on;
        sb(8'h06, cfg.four_wire_command_mode);
        fr_off;
    endtask
    // single-line program of n bytes; quad data for 32h
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n);
        logic [7:0] d;
        logic [11:0] p;
        bit ig;
        ig = (a[11:8] == 4'hF);
        permit_frame;
        chk(permit, 1'b1);
        fr_on;
        sb(op, 1'b0);
        sb(a[23:16], 1'b0);
        sb(a[15:8], 1'b0);
        sb(a[7:0], 1'b0);
        for (int i = 0; i < n; i++) begin
            d = 8'hC3 ^ 8'(i * 17);
            p = {a[11:8], a[7:0] + 8'(i)};
            sb(d, op == 8'h32);
            if (!ig) shadow[p] = shadow[p] & d;
        end
        fr_off;
        chk(flag, !ig);
        for (int t = 0; t < 3000 && flag; t++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk(flag, 1'b0);
        chk(permit, ig);
    endtask
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'hF;
        busy = 1'b0;
        wreq = 1'b0;
        wdone = 1'b0;
        wkind = 2'h0;
        waddr = 32'h0000_0000;
        cfg = 7'h46;
        for (int i = 0; i < 4096; i++) shadow[i] = 8'(i) ^ 8'h5A;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        chk({o_oe, permit, pvalid, wipe.valid, flag}, 32'h0);
        // four-wire, quad enable off: skip mode in with A5, used, left with FF
        qread(8'hEB, 32'h0000_0123, 8'hA5, 1'b0);
        qread(8'h00, 32'h0000_0456, 8'hFF, 1'b0);
        qread(8'hEC, 32'h0000_0789, 8'h00, 1'b0);
        // dummy equal to mode period: low mode nibble left floating high
        cfg <= 7'h42;
        qread(8'hEB, 32'h0000_0A5C, 8'h0F, 1'b0);
        busy <= 1'b1;
        qread(8'hEB, 32'h0000_0200, 8'h00, 1'b1);
        busy <= 1'b0;
        cfg <= 7'h26;
        prog(8'h02, 24'h0001FE, 3);
        prog(8'h32, 24'h000310, 4);
        prog(8'h02, 24'h000F10, 2);
        cfg <= 7'h46;
        qread(8'hEB, 32'h0000_01FE, 8'h00, 1'b0);
        qread(8'hEB, 32'h0000_0100, 8'h00, 1'b0);
        qread(8'hEB, 32'h0000_0310, 8'h00, 1'b0);
        qread(8'hEB, 32'h0000_0F10, 8'h00, 1'b0);
        // each wipe kind: pulse one cycle later, aligned base and size
        for (int k = 0; k < 3; k++) begin
            wkind <= 2'(k);
            waddr <= 32'h0001_2345;
            wreq <= 1'b1;
            @(posedge clk);
            wreq <= 1'b0;
            @(posedge clk);
            chk(wipe.valid, 1'b1);
            chk(wipe.size_log2, k ? 14 + k : 12);
            chk(wipe.base, 32'h0001_2345 & ~((32'h1 << (k ? 14 + k : 12)) - 32'h1));
            @(posedge clk);
            chk(wipe.valid, 1'b0);
        end
        wdone <= 1'b1;
        @(posedge clk);
        wdone <= 1'b0;
        repeat (2) @(posedge clk);
        chk(permit, 1'b0);
        // frozen block ignores a whole permit frame
        ce <= 1'b0;
        permit_frame;
        ce <= 1'b1;
        chk(permit, 1'b0);
        permit_frame;
        chk(permit, 1'b1);
        give_verdict;
    end
    // watchdog well past the expected run length
    initial begin
        #900000;
        fails++;
        give_verdict;
    end
endmodule
